// >>> src/adc_sync_requantizer_config_regs.v
// Sync and requantizer configuration registers of a multi-channel converter.
// Assumes a serial port decoder hands over address, data and one-cycle
// strobes already moved into the sample clock domain.
//
// Overview of operation
// - Divider-sync bit gates pulse to divider
// - Sync passes only when both enables set
// - Nothing syncs without master sync enable
// - Bit 4 picks pin or register control
// - Local writes hit only selected channels
// - Mode 000 selects 22 percent band
// - Mode 001 selects 33 percent band
// - Register enable turns requantizer on or off
// - Pin decides when bit 4 clear, with a valid tuning word
// - Six-bit tuning word sets band edges
// - 22 percent mode accepts 57 words
// - 33 percent mode accepts 34 words
// - Each step moves band half percent
`include "adc_sync_requantizer_consts.vh"
module adc_sync_requantizer_config_regs #(
    parameter CHANNELS = 4
) (
    input  wire                  core_clk,
    input  wire                  rst,
    input  wire                  clkEn,
    input  wire [7:0]            regAddr,
    input  wire [7:0]            regWriteData,
    input  wire                  regWrite,
    input  wire                  regRead,
    input  wire [CHANNELS-1:0]   channelSelect,
    input  wire [15:0]           selftestSignature,
    input  wire [CHANNELS-1:0]   modePin,
    input  wire                  syncIn,
    output reg  [7:0]            regReadData,
    output reg                   regReadValid,
    output reg                   dividerSync,
    output wire [CHANNELS-1:0]   requantActive,
    output wire [2*CHANNELS-1:0] bwSelect,
    output wire [CHANNELS-1:0]   tuneValid,
    output wire [8*CHANNELS-1:0] bandStartTenths
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    reg [CHANNELS-1:0] modeMeta;   // First stage, read only by modeSync
    reg [CHANNELS-1:0] modeSync;   // Safe copy of the mode pins
    reg                syncMeta;   // First stage of the sync pin
    reg                syncLevel;  // Safe copy of the sync pin
    reg                syncPrev;   // Previous level for edge detect

    // Pins are asynchronous to the sample clock, so two flops each
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            modeMeta  <= {CHANNELS{1'b0}};
            modeSync  <= {CHANNELS{1'b0}};
            syncMeta  <= 1'b0;
            syncLevel <= 1'b0;
            syncPrev  <= 1'b0;
        end else if (clkEn) begin
            modeMeta  <= modePin;
            modeSync  <= modeMeta;
            syncMeta  <= syncIn;
            syncLevel <= syncMeta;
            syncPrev  <= syncLevel;
        end
    end

    // ------------------------------------------------------------
    // Global sync control register
    // ------------------------------------------------------------
    reg [7:0] syncControl;         // Master and divider sync enables

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syncControl <= `RST_SYNC_CONTROL;
        end else if (clkEn && regWrite && regAddr == `ADDR_SYNC_CONTROL) begin
            syncControl <= regWriteData & `MASK_SYNC_CONTROL;
        end
    end

    // ------------------------------------------------------------
    // Divider sync pulse
    // ------------------------------------------------------------
    // Continuous mode: every rising sync edge passes while both bits set
    wire syncEdge = syncLevel & ~syncPrev;  // Rising edge of synced pin
    wire syncGate = syncControl[`BIT_MASTER_SYNC_ENABLE]
                  & syncControl[`BIT_DIVIDER_SYNC_ENABLE];

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dividerSync <= 1'b0;
        end else if (clkEn) begin
            dividerSync <= syncEdge & syncGate;
        end
    end

    // ------------------------------------------------------------
    // Per-channel local registers
    // ------------------------------------------------------------
    wire ctrlHit = regWrite && regAddr == `ADDR_REQUANTIZER_CONTROL;
    wire tuneHit = regWrite && regAddr == `ADDR_REQUANTIZER_TUNING;
    wire [8*CHANNELS-1:0] ctrlRegs;  // Stored control per channel
    wire [8*CHANNELS-1:0] tuneRegs;  // Stored tuning per channel

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChannel
            channel_config_slot uSlot (
                .core_clk        (core_clk),
                .rst             (rst),
                .clkEn           (clkEn),
                .ctrlWrite       (ctrlHit & channelSelect[ch]),
                .tuneWrite       (tuneHit & channelSelect[ch]),
                .writeData       (regWriteData),
                .modePinSync     (modeSync[ch]),
                .ctrlReg         (ctrlRegs[8*ch+7:8*ch]),
                .tuneReg         (tuneRegs[8*ch+7:8*ch]),
                .requantActive   (requantActive[ch]),
                .bwSelect        (bwSelect[2*ch+1:2*ch]),
                .tuneValid       (tuneValid[ch]),
                .bandStartTenths (bandStartTenths[8*ch+7:8*ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Local reads return the lowest selected channel; none selected reads 0
    reg [7:0] pickCtrl;
    reg [7:0] pickTune;
    reg       picked;
    integer   k;
    always @* begin
        pickCtrl = 8'h00;
        pickTune = 8'h00;
        picked   = 1'b0;
        for (k = 0; k < CHANNELS; k = k + 1) begin
            if (channelSelect[k] && !picked) begin
                pickCtrl = ctrlRegs[8*k +: 8];
                pickTune = tuneRegs[8*k +: 8];
                picked   = 1'b1;
            end
        end
    end

    reg [7:0] next_readData;
    always @* begin
        case (regAddr)
            // Signature is never stored here, so writes cannot touch it
            `ADDR_SELFTEST_SIGNATURE_LOW:  next_readData = selftestSignature[7:0];
            `ADDR_SELFTEST_SIGNATURE_HIGH: next_readData = selftestSignature[15:8];
            `ADDR_SYNC_CONTROL:            next_readData = syncControl;
            `ADDR_REQUANTIZER_CONTROL:     next_readData = pickCtrl;
            `ADDR_REQUANTIZER_TUNING:      next_readData = pickTune;
            default:                       next_readData = 8'h00;
        endcase
    end

    // Read data from a flop, valid one cycle after the strobe
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            regReadData  <= 8'h00;
            regReadValid <= 1'b0;
        end else if (clkEn) begin
            regReadValid <= regRead;
            if (regRead) begin
                regReadData <= next_readData;
            end
        end
    end
endmodule // adc_sync_requantizer_config_regs

// >>> src/adc_sync_requantizer_consts.vh
// Constants for the sync and requantizer configuration register block.
// Assumes 8-bit register addresses and 8-bit data from the serial port decoder.
`ifndef ADC_SYNC_REQUANTIZER_CONSTS_VH
`define ADC_SYNC_REQUANTIZER_CONSTS_VH
// Register offsets
`define ADDR_SELFTEST_SIGNATURE_LOW  8'h24
`define ADDR_SELFTEST_SIGNATURE_HIGH 8'h25
`define ADDR_SYNC_CONTROL            8'h3a
`define ADDR_REQUANTIZER_CONTROL     8'h3c
`define ADDR_REQUANTIZER_TUNING      8'h3e
// Reset values
`define RST_SYNC_CONTROL             8'h00
`define RST_REQUANTIZER_CONTROL      8'h00
`define RST_REQUANTIZER_TUNING       8'h1c
// Writable masks, reserved bits are cleared
`define MASK_SYNC_CONTROL            8'h03
`define MASK_REQUANTIZER_CONTROL     8'h1f
`define MASK_REQUANTIZER_TUNING      8'h3f
// Field positions
`define BIT_MASTER_SYNC_ENABLE       0
`define BIT_DIVIDER_SYNC_ENABLE      1
`define BIT_REQUANTIZER_ENABLE       0
`define BIT_MODE_PIN_DISABLE         4
`define FIELD_BW_MODE_HI             3
`define FIELD_BW_MODE_LO             1
// Bandwidth modes
`define BW_MODE_22PCT                3'h0
`define BW_MODE_33PCT                3'h1
// Count of valid tuning words per mode
`define TUNING_COUNT_22PCT           6'h39
`define TUNING_COUNT_33PCT           6'h22
// Band step of one tuning increment, in tenths of a percent of sample rate
`define TUNING_STEP_TENTHS_PCT       8'h05
`endif

// >>> src/channel_config_slot.v
// One channel's local requantizer settings and resolved controls.
// Assumes writes arrive already decoded and qualified by channel selection.
`include "adc_sync_requantizer_consts.vh"
module channel_config_slot (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       clkEn,
    input  wire       ctrlWrite,
    input  wire       tuneWrite,
    input  wire [7:0] writeData,
    input  wire       modePinSync,
    output reg  [7:0] ctrlReg,
    output reg  [7:0] tuneReg,
    output reg        requantActive,
    output reg  [1:0] bwSelect,
    output reg        tuneValid,
    output reg  [7:0] bandStartTenths
);
    // ------------------------------------------------------------
    // Combinational decode of stored settings
    // ------------------------------------------------------------
    reg next_active;            // Active decision before the register
    reg next_valid;             // Tuning word inside its mode's range
    reg [1:0] next_bw;          // 0 none, 1 for 22 pct, 2 for 33 pct
    always @* begin
        if (ctrlReg[`BIT_MODE_PIN_DISABLE]) begin
            next_active = ctrlReg[`BIT_REQUANTIZER_ENABLE];
        end else begin
            next_active = modePinSync;
        end
        case (ctrlReg[`FIELD_BW_MODE_HI:`FIELD_BW_MODE_LO])
            `BW_MODE_22PCT: begin
                next_bw    = 2'h1;
                next_valid = tuneReg[5:0] < `TUNING_COUNT_22PCT;
            end
            `BW_MODE_33PCT: begin
                next_bw    = 2'h2;
                next_valid = tuneReg[5:0] < `TUNING_COUNT_33PCT;
            end
            default: begin
                // Undefined mode: no band, datapath should bypass
                next_bw    = 2'h0;
                next_valid = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Stored settings and registered outputs
    // ------------------------------------------------------------
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlReg         <= `RST_REQUANTIZER_CONTROL;
            tuneReg         <= `RST_REQUANTIZER_TUNING;
            requantActive   <= 1'b0;
            bwSelect        <= 2'h0;
            tuneValid       <= 1'b0;
            bandStartTenths <= 8'h00;
        end else if (clkEn) begin
            if (ctrlWrite) begin
                ctrlReg <= writeData & `MASK_REQUANTIZER_CONTROL;
            end
            if (tuneWrite) begin
                tuneReg <= writeData & `MASK_REQUANTIZER_TUNING;
            end
            requantActive   <= next_active & next_valid;
            bwSelect        <= next_bw;
            tuneValid       <= next_valid;
            // Band edge moves half a percent per step
            bandStartTenths <= {2'h0, tuneReg[5:0]} * `TUNING_STEP_TENTHS_PCT;
        end
    end
endmodule // channel_config_slot

// >>> verification/adc_sync_requantizer_config_regs_chk.sv
// Checker for the sync and requantizer register block.
// Assumes one clock domain; sees only the top module ports.
module adc_sync_requantizer_config_regs_chk #(parameter CHANNELS = 4) (
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic                  clkEn,
    input wire logic [7:0]            regAddr,
    input wire logic [7:0]            regWriteData,
    input wire logic                  regWrite,
    input wire logic                  regRead,
    input wire logic [CHANNELS-1:0]   channelSelect,
    input wire logic [15:0]           selftestSignature,
    input wire logic                  syncIn,
    input wire logic [7:0]            regReadData,
    input wire logic                  regReadValid,
    input wire logic                  dividerSync,
    input wire logic [8*CHANNELS-1:0] bandStartTenths
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire rdOk = clkEn && regRead; // Read taken this edge
    logic [1:0] syncCtl;          // Shadow of both sync enables
    // Shadow tracks the global sync register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) syncCtl <= 2'h0;
        else if (clkEn && regWrite && regAddr == 8'h3a) syncCtl <= regWriteData[1:0];
    end
    sequence syncEdge;
        $rose(syncIn) && syncCtl == 2'h3 && clkEn;
    endsequence
    // Band product above 255 is left unchecked on purpose
    property bandStep;
        logic [5:0] w;
        (clkEn && regWrite && regAddr == 8'h3e && channelSelect[0] &&
         regWriteData[5:0] < 6'd52, w = regWriteData[5:0]) |-> ##2 bandStartTenths[7:0] == 8'(w * 5);
    endproperty
    read_strobe_a: assert property (rdOk |=> regReadValid) else $error("read unanswered");
    unmapped_zero_a: assert property (rdOk && !(regAddr inside {8'h24, 8'h25, 8'h3a, 8'h3c, 8'h3e})
        |=> regReadData == 8'h00) else $error("unmapped read not zero");
    sync_reserved_a: assert property (rdOk && regAddr == 8'h3a |=> regReadData[7:2] == 6'h00)
        else $error("sync reserved bits set");
    sig_low_a: assert property (rdOk && regAddr == 8'h24 |=> regReadData == $past(selftestSignature[7:0]))
        else $error("signature low wrong");
    sync_master_a: assert property (dividerSync |-> syncCtl[0]) else $error("sync without master");
    sync_divider_a: assert property (dividerSync |-> syncCtl[1]) else $error("sync without gate");
    sync_pass_a: assert property (syncEdge |-> ##3 dividerSync) else $error("sync pulse missing");
    band_step_a: assert property (bandStep) else $error("band start wrong");
endmodule // adc_sync_requantizer_config_regs_chk
bind adc_sync_requantizer_config_regs adc_sync_requantizer_config_regs_chk #(.CHANNELS(CHANNELS))
    chk_i (.core_clk, .rst, .clkEn, .regAddr, .regWriteData, .regWrite, .regRead, .channelSelect,
           .selftestSignature, .syncIn, .regReadData, .regReadValid, .dividerSync, .bandStartTenths);

// >>> verification/adc_sync_requantizer_config_regs_tb.sv
// Self-checking bench for the sync and requantizer register block.
// Assumes four channels and the host model on the register port.
module adc_sync_requantizer_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, syncIn = 1'b0;
    logic [3:0]  channelSelect = 4'hf, modePin = 4'h0, requantActive, tuneValid;
    logic [7:0]  regAddr, regWriteData, regReadData, bwSelect;
    logic        regWrite, regRead, regReadValid, dividerSync;
    logic [31:0] bandStartTenths;
    logic [15:0] selftestSignature = 16'h5aa5; // Fixed signature pattern
    int          n_fail = 0, checks = 0;
    logic [7:0]  q;
    logic [7:0]  tab [4][3] = '{'{8'h13, 8'd33, 8'h1}, '{8'h13, 8'd34, 8'h0},
                                '{8'h11, 8'd56, 8'h1}, '{8'h11, 8'd57, 8'h0}};
    adc_sync_requantizer_config_regs dut (.core_clk, .rst, .clkEn, .regAddr, .regWriteData,
        .regWrite, .regRead, .channelSelect, .selftestSignature, .modePin, .syncIn, .regReadData,
        .regReadValid, .dividerSync, .requantActive, .bwSelect, .tuneValid, .bandStartTenths);
    serial_host_model host (.core_clk, .regReadData, .regReadValid, .regAddr, .regWriteData,
        .regWrite, .regRead);
    initial forever #50 core_clk = ~core_clk;
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic v;
        host.access(1'b1, a, d, q, v);
    endtask
    // Read also checks the one-cycle valid
    task automatic rd(input logic [7:0] a);
        logic v;
        host.access(1'b0, a, 8'h00, q, v);
        chk("read valid", 16'(v), 16'h1);
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reserved;
        rd(8'h3e); chk("tune reset", q, 8'h1c);
        chk("band reset", bandStartTenths[7:0], 8'h8c);
        wr(8'h3a, 8'hfc); rd(8'h3a); chk("sync mask", q, 8'h00);
        // Clock enable low must freeze the register against a write
        clkEn = 1'b0;
        wr(8'h3a, 8'h03);
        clkEn = 1'b1;
        rd(8'h3a); chk("frozen sync", q, 8'h00);
        wr(8'h3c, 8'hff); rd(8'h3c); chk("ctrl mask", q, 8'h1f);
        wr(8'h3e, 8'hc5); rd(8'h3e); chk("tune mask", q, 8'h05);
        wr(8'h24, 8'h00); rd(8'h24); chk("sig low", q, 8'ha5);
        wr(8'h25, 8'h00); rd(8'h25); chk("sig high", q, 8'h5a);
        rd(8'h40); chk("unmapped", q, 8'h00);
        $display("test reserved done");
    endtask
    // Every enable combination; only both set passes a pulse
    task automatic t_sync;
        int n;
        for (int i = 0; i < 4; i++) begin
            wr(8'h3a, 8'(i));
            n = 0;
            syncIn = 1'b1;
            repeat (6) @(negedge core_clk) if (dividerSync === 1'b1) n++;
            syncIn = 1'b0;
            repeat (3) @(negedge core_clk);
            chk("sync pulses", 16'(n), 16'(i == 3));
        end
        wr(8'h3a, 8'h00);
        $display("test sync done");
    endtask
    // Local writes, pin against register control
    task automatic t_local;
        wr(8'h3c, 8'h00); wr(8'h3e, 8'h1c);
        channelSelect = 4'h1;
        wr(8'h3c, 8'h11); repeat (5) @(negedge core_clk);
        chk("reg on", requantActive, 4'h1);
        channelSelect = 4'h2;
        rd(8'h3c); chk("other channel", q, 8'h00);
        modePin = 4'hf; repeat (5) @(negedge core_clk);
        chk("pin on", requantActive, 4'hf);
        channelSelect = 4'h1;
        wr(8'h3c, 8'h10); repeat (5) @(negedge core_clk);
        chk("pin ignored", requantActive, 4'he);
        modePin = 4'h0;
        $display("test local done");
    endtask
    // Mode boundaries: last valid and first invalid word
    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            wr(8'h3c, tab[i][0]); wr(8'h3e, tab[i][1]); repeat (3) @(negedge core_clk);
            chk("tune valid", tuneValid[0], tab[i][2]);
            chk("bw mode", bwSelect[1:0], {tab[i][0][1], !tab[i][0][1]});
            chk("active", requantActive[0], tab[i][2]);
        end
        $display("test modes done");
    endtask
    initial begin
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        t_reserved;
        t_sync;
        t_local;
        t_modes;
        summarize;
    end
    // Hang guard counted as a mismatch
    initial begin
        #200000;
        n_fail++;
        summarize;
    end
endmodule // adc_sync_requantizer_config_regs_tb

// >>> verification/serial_host_model.sv
// Host model: issues decoded register writes and reads to the block.
// Assumes the bench calls access right after a falling clock edge.
module serial_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] regReadData,
    input  wire logic       regReadValid,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWriteData,
    output logic            regWrite,
    output logic            regRead
);
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------------------------------------
    // Idle port; write and read strobes start low, address and data at zero
    // -----------------------------------------------------------
    initial begin
        regAddr = 8'h00;
        regWriteData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // One access; request held for exactly the taking edge
    task automatic access(input logic w, input logic [7:0] a, d,
                          output logic [7:0] q, output logic v);
        @(negedge core_clk);
        regAddr = a;
        regWriteData = d;
        regWrite = w;
        regRead = !w;
        @(negedge core_clk);
        q = regReadData;
        v = regReadValid;
        regWrite = 1'b0;
        regRead = 1'b0;
        // Released lines show junk, so stale values cannot pass
        regAddr = ~a;
        regWriteData = ~d;
    endtask
endmodule // serial_host_model
